// *** inc/adc_sel_pkg.sv ***
// Package: register map, field layout and reset values of the converter control block.
// Assumes a 32-bit APB slave with registers in the low byte of aligned words.
// How it works
// - Format 0: result bits 11..4 in high byte, 3..0 in low byte upper nibble.
// - Format 1: result bits 11..8 in high byte low nibble, 7..0 in low byte.
// - Result bits not carrying data under the chosen format read zero.
// - Four-bit channel field picks one of sixteen pins, code equals index.
// - Source codes 0000, 0100 and 11xx route the external channel.
// - Codes 0001-0011 supply fractions, 0101-0111 amplifier fractions, 10xx ground.
// - Any internal source disconnects every external channel, whatever the channel field.
// - Three-bit clock field divides system clock by two to the code.
// - Unimplemented bits of the control registers read back zero.
// - Reference control bit 7 enables the reference amplifier.
// - Amplifier input: 0 external pin, 1 bandgap; bandgap disconnects the pin.
// - Reference select: 00 supply, 01 external pin, 1x amplifier output.
// - Internal reference selection disconnects the external reference pins.
// - Gain codes 00..11 select gains 1, 1.667, 2.5, 3.333.
// - Bandgap register bit 0 enables the bandgap circuit.
package adc_sel_pkg;
	localparam logic [11:0] ADDR_CTRL0      = 12'h000;
	localparam logic [11:0] ADDR_IN_CLK     = 12'h004;
	localparam logic [11:0] ADDR_REF_CTRL   = 12'h008;
	localparam logic [11:0] ADDR_BANDGAP    = 12'h00c;
	localparam logic [11:0] ADDR_RESULT_LO  = 12'h010;
	localparam logic [11:0] ADDR_RESULT_HI  = 12'h014;
	localparam logic [7:0]  RST_REG         = 8'h00;
	localparam logic [7:0]  MASK_CTRL0      = 8'h1f;
	localparam logic [7:0]  MASK_IN_CLK     = 8'hf7;
	localparam logic [7:0]  MASK_REF_CTRL   = 8'h9f;
	localparam logic [7:0]  MASK_BANDGAP    = 8'h01;
	localparam int FMT_BIT  = 4;
	localparam int CH_LSB   = 0;
	localparam int SRC_LSB  = 4;
	localparam int CKD_LSB  = 0;
	localparam int AMP_EN_BIT = 7;
	localparam int AMP_IN_BIT = 4;
	localparam int REF_LSB  = 2;
	localparam int GAIN_LSB = 0;
	localparam int BG_BIT   = 0;
	localparam int NUM_CH   = 16;
	localparam int NUM_SRC  = 8;
	localparam int NUM_DIV  = 8;
	// One-hot input source routes
	localparam int SRC_EXT = 0;
	localparam int SRC_AVDD = 1;
	localparam int SRC_AVDD2 = 2;
	localparam int SRC_AVDD4 = 3;
	localparam int SRC_VR = 4;
	localparam int SRC_VR2 = 5;
	localparam int SRC_VR4 = 6;
	localparam int SRC_GND = 7;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	typedef enum logic [2:0] {
		APB_IDLE   = 3'b001,
		APB_SETUP  = 3'b010,
		APB_ACCESS = 3'b100
	} apb_state_t;
endpackage

// *** rtl/adc_src_decode.sv ***
// Decodes the input source and channel fields into one-hot analog selects.
// Combinational; the parent registers the outputs.
`timescale 1ns/1ns
module adc_src_decode (
	input  wire logic [3:0]                     src_code, // Input source field
	input  wire logic [3:0]                     ch_code,  // External channel field
	output logic [adc_sel_pkg::NUM_SRC-1:0]     src_oh,   // One-hot source route
	output logic [adc_sel_pkg::NUM_CH-1:0]      ch_oh     // One-hot channel switch
);
	import adc_sel_pkg::*;
	wire ext_route = (src_code == 4'h0) || (src_code == 4'h4) || (src_code[3:2] == 2'b11);
	wire gnd_route = (src_code[3:2] == 2'b10);
	genvar i;
	generate
		for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
			// Gated by the external route so pins never join an internal signal
			assign ch_oh[i] = ext_route && (ch_code == 4'(i));
		end
	endgenerate
	assign src_oh[SRC_EXT]   = ext_route;
	assign src_oh[SRC_AVDD]  = (src_code == 4'h1);
	assign src_oh[SRC_AVDD2] = (src_code == 4'h2);
	assign src_oh[SRC_AVDD4] = (src_code == 4'h3);
	assign src_oh[SRC_VR]    = (src_code == 4'h5);
	assign src_oh[SRC_VR2]   = (src_code == 4'h6);
	assign src_oh[SRC_VR4]   = (src_code == 4'h7);
	assign src_oh[SRC_GND]   = gnd_route;
endmodule

// *** rtl/adc_clk_div.sv ***
// Converter clock divider: a counter that restarts at a limit set by the divide code.
// The output is a one-cycle enable pulse at the divided rate, not a clock.
`timescale 1ns/1ns
module adc_clk_div (
	input  wire logic       clk_sys,  // System clock
	input  wire logic       sys_rst,  // Synchronous reset, active high
	input  wire logic [2:0] div_code, // Divide by two to this power
	output logic            tick      // Converter clock enable pulse
);
	import adc_sel_pkg::*;
	logic [6:0] count;
	logic [6:0] limit;
	assign limit = 7'((8'h01 << div_code) - 8'h01);
	always_ff @(posedge clk_sys) begin
		if (sys_rst || count >= limit) begin
			count <= 7'h00;
		end else begin
			count <= count + 7'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		tick <= !sys_rst && (count >= limit);
	end
endmodule

// *** rtl/adc_input_reference_select.sv ***
// Top: APB register file of the converter input, clock and reference selects.
// Assumes a conversion result word arrives from the converter core on result_data.
`timescale 1ns/1ns
module adc_input_reference_select (
	input  wire logic                          clk_sys,          // System clock, 250 MHz
	input  wire logic                          sys_rst,          // Synchronous reset, active high
	input  wire logic                          psel,             // APB select
	input  wire logic                          penable,          // APB enable
	input  wire logic                          pwrite,           // APB direction
	input  wire logic [11:0]                   paddr,            // APB byte address
	input  wire logic [31:0]                   pwdata,           // APB write data
	output logic                               pready,           // APB ready
	output logic [31:0]                        prdata,           // APB read data
	output logic                               pslverr,          // APB error
	input  wire logic [11:0]                   result_data,      // Conversion result
	output logic [adc_sel_pkg::NUM_CH-1:0]     analog_input_pin, // One-hot channel switches
	output logic [adc_sel_pkg::NUM_SRC-1:0]    input_route,      // One-hot source route
	output logic                               conv_clk_tick,    // Converter clock enable
	output logic                               ref_amp_enable,   // Amplifier enable
	output logic                               ext_amp_input_pin,// Amplifier from external pin
	output logic                               bandgap_voltage,  // Amplifier from bandgap
	output logic [2:0]                         ref_route,        // Supply, ext pin, amp output
	output logic [3:0]                         ref_amp_gain,     // One-hot gain 1,1.667,2.5,3.333
	output logic                               bandgap_enable,   // Bandgap circuit enable
	output logic [7:0]                         result_high_byte, // Formatted high byte
	output logic [7:0]                         result_low_byte   // Formatted low byte
);
	import adc_sel_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]  ctrl0;
	logic [7:0]  adc_input_and_clock_select;
	logic [7:0]  adc_reference_control;
	logic [7:0]  bandgap_control;
	apb_state_t  state;
	apb_state_t  next_state;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire       setup    = psel && !penable;
	wire       wr_take  = (state == APB_ACCESS) && psel && penable && pwrite && pready;
	wire       hit_c0   = (paddr == ADDR_CTRL0);
	wire       hit_ic   = (paddr == ADDR_IN_CLK);
	wire       hit_rc   = (paddr == ADDR_REF_CTRL);
	wire       hit_bg   = (paddr == ADDR_BANDGAP);
	wire       hit_lo   = (paddr == ADDR_RESULT_LO);
	wire       hit_hi   = (paddr == ADDR_RESULT_HI);
	wire       mapped   = hit_c0 || hit_ic || hit_rc || hit_bg || hit_lo || hit_hi;
	wire       ro_hit   = hit_lo || hit_hi;
	wire [7:0] wbyte    = pwdata[7:0];

	////////////////////////////////////////////////////////////////////////////
	// Result formatting
	wire        fmt_right = ctrl0[FMT_BIT];
	wire [7:0]  fmt_hi    = fmt_right ? {4'h0, result_data[11:8]} : result_data[11:4];
	wire [7:0]  fmt_lo    = fmt_right ? result_data[7:0] : {result_data[3:0], 4'h0};

	wire [7:0] rd_byte =
		hit_c0 ? (ctrl0 & MASK_CTRL0) :
		hit_ic ? (adc_input_and_clock_select & MASK_IN_CLK) :
		hit_rc ? (adc_reference_control & MASK_REF_CTRL) :
		hit_bg ? (bandgap_control & MASK_BANDGAP) :
		hit_lo ? fmt_lo :
		hit_hi ? fmt_hi : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Decoded selects
	logic [NUM_SRC-1:0] src_oh;
	logic [NUM_CH-1:0]  ch_oh;
	logic               tick;
	adc_src_decode u_dec (
		.src_code (adc_input_and_clock_select[SRC_LSB +: 4]),
		.ch_code  (ctrl0[CH_LSB +: 4]),
		.src_oh   (src_oh),
		.ch_oh    (ch_oh)
	);
	adc_clk_div u_div (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.div_code (adc_input_and_clock_select[CKD_LSB +: 3]),
		.tick     (tick)
	);

	wire [1:0] ref_code  = adc_reference_control[REF_LSB +: 2];
	wire [1:0] gain_code = adc_reference_control[GAIN_LSB +: 2];
	wire       amp_bg    = adc_reference_control[AMP_IN_BIT];
	// External reference pin switched only for code 01
	wire [2:0] next_ref  = {ref_code[1], ref_code == 2'b01, ref_code == 2'b00};
	wire [3:0] next_gain = 4'(5'h01 << gain_code);

	////////////////////////////////////////////////////////////////////////////
	// APB state: one wait state, answer in the second access cycle
	always_comb begin
		next_state = state;
		case (state)
			APB_IDLE: begin
				if (setup) begin
					next_state = APB_SETUP;
				end
			end
			APB_SETUP: begin
				next_state = (psel && penable) ? APB_ACCESS : APB_IDLE;
			end
			APB_ACCESS: begin
				next_state = setup ? APB_SETUP : APB_IDLE;
			end
			default: begin
				next_state = APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= APB_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= ZERO_WORD;
			pslverr <= 1'b0;
		end else begin
			pready  <= (state == APB_SETUP) && psel && penable;
			prdata  <= ((state == APB_SETUP) && psel && penable && !pwrite) ? {24'h00_0000, rd_byte} : ZERO_WORD;
			pslverr <= (state == APB_SETUP) && psel && penable && (!mapped || (pwrite && ro_hit));
		end
	end

	// Write lands at the edge where the master samples pready high, not where it is launched
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl0                      <= RST_REG;
			adc_input_and_clock_select <= RST_REG;
			adc_reference_control      <= RST_REG;
			bandgap_control            <= RST_REG;
		end else if (wr_take) begin
			if (hit_c0) begin
				ctrl0 <= wbyte & MASK_CTRL0;
			end
			if (hit_ic) begin
				adc_input_and_clock_select <= wbyte & MASK_IN_CLK;
			end
			if (hit_rc) begin
				adc_reference_control <= wbyte & MASK_REF_CTRL;
			end
			if (hit_bg) begin
				bandgap_control <= wbyte & MASK_BANDGAP;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered analog selects, converter clock tick and result bytes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			analog_input_pin  <= '0;
			input_route       <= '0;
			conv_clk_tick     <= 1'b0;
			ref_amp_enable    <= 1'b0;
			ext_amp_input_pin <= 1'b0;
			bandgap_voltage   <= 1'b0;
			ref_route         <= 3'h0;
			ref_amp_gain      <= 4'h0;
			bandgap_enable    <= 1'b0;
			result_high_byte  <= 8'h00;
			result_low_byte   <= 8'h00;
		end else begin
			analog_input_pin  <= ch_oh;
			input_route       <= src_oh;
			conv_clk_tick     <= tick;
			ref_amp_enable    <= adc_reference_control[AMP_EN_BIT];
			ext_amp_input_pin <= !amp_bg;
			bandgap_voltage   <= amp_bg;
			ref_route         <= next_ref;
			ref_amp_gain      <= next_gain;
			bandgap_enable    <= bandgap_control[BG_BIT];
			result_high_byte  <= fmt_hi;
			result_low_byte   <= fmt_lo;
		end
	end
endmodule

// *** verif/adc_sel_checker_assertions.sv ***
// Checker: bus handshake and select-decode properties of the converter control block.
// Sees only the top module ports; bound to every instance of the top below.
`timescale 1ns/1ns
module adc_sel_checker (
	input wire logic                          clk_sys,           // System clock
	input wire logic                          sys_rst,           // Synchronous reset
	input wire logic                          psel,              // APB select
	input wire logic                          penable,           // APB enable
	input wire logic                          pready,            // APB ready
	input wire logic [31:0]                   prdata,            // APB read data
	input wire logic                          pslverr,           // APB error
	input wire logic [11:0]                   result_data,       // Conversion result
	input wire logic [adc_sel_pkg::NUM_CH-1:0]  analog_input_pin,  // Channel switches
	input wire logic [adc_sel_pkg::NUM_SRC-1:0] input_route,       // Source route
	input wire logic                          ext_amp_input_pin, // Amp from pin
	input wire logic                          bandgap_voltage,   // Amp from bandgap
	input wire logic [2:0]                    ref_route,         // Reference route
	input wire logic [3:0]                    ref_amp_gain,      // Gain select
	input wire logic [7:0]                    result_high_byte,  // High result byte
	input wire logic [7:0]                    result_low_byte    // Low result byte
);
	import adc_sel_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	// Outputs are zero for one edge after reset, so decode checks skip it
	property p_ready; s_access |=> s_answer; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_rdata; !pready |-> prdata == ZERO_WORD; endproperty
	property p_upper; (prdata & 32'hffff_ff00) == ZERO_WORD; endproperty
	property p_route; !$past(sys_rst) |-> $onehot(input_route); endproperty
	property p_ext_off; !input_route[SRC_EXT] |-> analog_input_pin == '0; endproperty
	property p_chan; !$past(sys_rst) && input_route[SRC_EXT] |-> $onehot(analog_input_pin); endproperty
	property p_amp_in; !$past(sys_rst) |-> ext_amp_input_pin != bandgap_voltage; endproperty
	property p_ref; !$past(sys_rst) |-> $onehot(ref_route); endproperty
	property p_gain; !$past(sys_rst) |-> $onehot(ref_amp_gain); endproperty
	property p_result;
		!$past(sys_rst) |-> {result_high_byte, result_low_byte} == {$past(result_data), 4'h0}
			|| {result_high_byte, result_low_byte} == {4'h0, $past(result_data)};
	endproperty
	////////////////////////////////////////////////////////////////////////////////
	a_ready: assert property (p_ready) else $error("pready not one pulse after access");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_rdata: assert property (p_rdata) else $error("prdata not zero outside answer");
	a_upper: assert property (p_upper) else $error("prdata upper bits set");
	a_route: assert property (p_route) else $error("input route not one-hot");
	a_ext_off: assert property (p_ext_off) else $error("channel on with internal source");
	a_chan: assert property (p_chan) else $error("channel select not one-hot");
	a_amp_in: assert property (p_amp_in) else $error("amp input pin and bandgap both on");
	a_ref: assert property (p_ref) else $error("reference route not one-hot");
	a_gain: assert property (p_gain) else $error("gain select not one-hot");
	a_result: assert property (p_result) else $error("result bytes not in either format");
endmodule
bind adc_input_reference_select adc_sel_checker u_chk (.clk_sys, .sys_rst, .psel, .penable, .pready, .prdata,
	.pslverr, .result_data, .analog_input_pin, .input_route, .ext_amp_input_pin, .bandgap_voltage, .ref_route,
	.ref_amp_gain, .result_high_byte, .result_low_byte);

// *** verif/adc_input_reference_select_tb.sv ***
// Testbench: APB register tests and select-output checks of the converter control block.
// Drives every port itself; the checker is bound from its own file.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin err_total++; $display("Error %s expected %h seen %h", nm, e, g); end end
module adc_input_reference_select_tb;
	import adc_sel_pkg::*;
	logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, conv_clk_tick;
	logic        ref_amp_enable, ext_amp_input_pin, bandgap_voltage, bandgap_enable;
	logic [11:0] paddr, result_data;
	logic [31:0] pwdata, prdata;
	logic [15:0] analog_input_pin;
	logic [7:0]  input_route, result_high_byte, result_low_byte;
	logic [2:0]  ref_route;
	logic [3:0]  ref_amp_gain;
	int          err_total = 0;
	int          n_tests = 0;
	adc_input_reference_select dut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .result_data, .analog_input_pin, .input_route, .conv_clk_tick, .ref_amp_enable,
		.ext_amp_input_pin, .bandgap_voltage, .ref_route, .ref_amp_gain, .bandgap_enable, .result_high_byte,
		.result_low_byte);
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Holds the request until pready is seen; one idle edge after keeps psel from two writes in a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int k;
		k = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			err_total++;
			complete_run();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic ee);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, {24'h00_0000, d}, r, e);
		`CHK("write error", ee, e)
		// Write lands as pready is sampled; the registered selects follow one edge later
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ee);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, ZERO_WORD, r, e);
		`CHK("read data", x, r)
		`CHK("read error", ee, e)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		logic [7:0] msk [4];
		logic [3:0] sv;
		logic [4:0] rv;
		logic       ext;
		int         cnt;
		msk = '{8'h1f, 8'hf7, 8'h9f, 8'h01};
		{sys_rst, psel, penable, pwrite, paddr, pwdata, result_data} = {4'h8, 12'h000, ZERO_WORD, 12'habc};
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		`CHK("reset amp pin", 1'b1, ext_amp_input_pin)
		`CHK("reset ref route", 3'b001, ref_route)
		`CHK("reset input route", 8'h01, input_route)
		for (int i = 0; i < 4; i++) begin
			rd(12'(4 * i), ZERO_WORD, 1'b0);
			wr(12'(4 * i), 8'hff, 1'b0);
			rd(12'(4 * i), {24'h00_0000, msk[i]}, 1'b0);
		end
		`CHK("bandgap on", 1'b1, bandgap_enable)
		wr(ADDR_BANDGAP, 8'hfe, 1'b0);
		`CHK("bandgap off", 1'b0, bandgap_enable)
		wr(ADDR_RESULT_LO, 8'hff, 1'b1);
		rd(12'h018, ZERO_WORD, 1'b1);
		$display("Test registers done");
		wr(ADDR_CTRL0, 8'h00, 1'b0);
		`CHK("result high", 8'hab, result_high_byte)
		`CHK("result low", 8'hc0, result_low_byte)
		rd(ADDR_RESULT_HI, 32'h0000_00ab, 1'b0);
		rd(ADDR_RESULT_LO, 32'h0000_00c0, 1'b0);
		wr(ADDR_CTRL0, 8'h10, 1'b0);
		`CHK("result high", 8'h0a, result_high_byte)
		`CHK("result low", 8'hbc, result_low_byte)
		rd(ADDR_RESULT_HI, 32'h0000_000a, 1'b0);
		rd(ADDR_RESULT_LO, 32'h0000_00bc, 1'b0);
		$display("Test format done");
		for (int s = 0; s < 16; s++) begin
			sv = 4'(s);
			ext = (sv == 4'h0) || (sv == 4'h4) || (sv[3:2] == 2'b11);
			wr(ADDR_CTRL0, {4'h0, ~sv}, 1'b0);
			wr(ADDR_IN_CLK, {sv, 4'h0}, 1'b0);
			`CHK("input route", ext ? 8'h01 : (sv[3] ? 8'h80 : 8'h01 << (3 * sv[2] + sv[1:0])), input_route)
			`CHK("channel", ext ? 16'h0001 << (~sv) : 16'h0000, analog_input_pin)
		end
		$display("Test sources done");
		// Bandgap on first, then a settling gap before it may feed the amplifier
		wr(ADDR_BANDGAP, 8'h01, 1'b0);
		repeat (16) @(posedge clk_sys);
		`CHK("bandgap on", 1'b1, bandgap_enable)
		// Shared pin functions of the reference pins sit outside this block; taken as set up
		for (int v = 0; v < 32; v++) begin
			rv = 5'(v);
			wr(ADDR_REF_CTRL, {rv[0], 2'b11, rv}, 1'b0);
			rd(ADDR_REF_CTRL, {24'h00_0000, rv[0], 2'b00, rv}, 1'b0);
			`CHK("amp enable", rv[0], ref_amp_enable)
			`CHK("amp input", {rv[4], ~rv[4]}, {bandgap_voltage, ext_amp_input_pin})
			`CHK("ref route", rv[3] ? 3'b100 : (rv[2] ? 3'b010 : 3'b001), ref_route)
			`CHK("gain", 4'h1 << rv[1:0], ref_amp_gain)
		end
		$display("Test reference done");
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_IN_CLK, {5'h00, 3'(c)}, 1'b0);
			cnt = 0;
			repeat (256) begin
				@(posedge clk_sys);
				if (conv_clk_tick === 1'b1) cnt++;
			end
			`CHK("tick count", 256 >> c, cnt)
		end
		$display("Test divider done");
		complete_run();
	end
endmodule
